// ==== verilog/wdg_pkg.sv ====
// Shared constants and types for the watchdog downcounter block
package wdg_pkg;
  // Register byte addresses on the APB
  localparam logic [7:0] WDG_CNT_ADDR = 8'hd8; // Counter and control
  localparam logic [7:0] WDG_CTL_ADDR = 8'hdc; // Power and interrupt control
  // Reset values
  localparam logic [7:0] WDG_CNT_RESET = 8'hfe; // Register view after reset
  localparam logic [6:0] WDG_PHYS_RESET = 7'h7f; // Physical counter after reset
  // Field positions of the counter register
  localparam int WDG_C_POS = 0; // Activation bit
  localparam int WDG_SR_POS = 1; // Software reset bit
  localparam int WDG_T_LSB = 2; // First period bit (physical MSB)
  localparam int WDG_T_BITS = 6; // Number of period bits
  // Field positions of the control register
  localparam int CTL_GEN_POS = 0; // Global interrupt enable
  localparam int CTL_STOP_POS = 1; // Write one: STOP instruction
  localparam int CTL_WAIT_POS = 2; // Write one: WAIT instruction
  localparam int CTL_WAITST_POS = 4; // Read: core waiting
  localparam int CTL_STOPST_POS = 5; // Read: core stopped
  localparam int CTL_ACT_POS = 6; // Read: watchdog active
  localparam int CTL_HWOPT_POS = 7; // Read: hardware activation option
  // Timing in oscillator cycles
  localparam int WDG_TICK_CYCLES = 3072; // Cycles per counter step
  localparam int WDG_MIN_TIMEOUT = WDG_TICK_CYCLES; // Shortest period
  localparam int WDG_MAX_TIMEOUT = 64 * WDG_TICK_CYCLES; // Longest period
  localparam logic [11:0] WDG_PRE_LAST = 12'(WDG_TICK_CYCLES - 1);
  // Core power states
  typedef enum logic [1:0] {WDG_RUN, WDG_WAIT, WDG_STOP} wdg_pwr_e;
endpackage : wdg_pkg

// ==== verilog/wdg_prescaler.sv ====
// Step prescaler: one tick every counter step while running
`timescale 1ns/100ps
module wdg_prescaler import wdg_pkg::*; (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic run,
  input wire logic clear,
  output logic tick
);
  logic [11:0] pre_reg; // Cycles counted in the current step
  logic [11:0] pre_next;

  // Tick on the last cycle of a step, never while cleared or frozen
  assign tick = run && !clear && (pre_reg == WDG_PRE_LAST);

  // Next count: restart on clear, hold when frozen, wrap at step end
  always_comb begin
    pre_next = pre_reg;
    if (clear) begin
      pre_next = 12'h000;
    end else if (tick) begin
      pre_next = 12'h000;
    end else if (run) begin
      pre_next = pre_reg + 12'h001;
    end
  end

  // Register the count
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pre_reg <= 12'h000;
    end else begin
      pre_reg <= pre_next;
    end
  end
endmodule : wdg_prescaler

// ==== verilog/wdg_top.sv ====
// Digital watchdog downcounter with APB register access
`timescale 1ns/100ps
module wdg_top import wdg_pkg::*; (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic opt_hw_activation,
  input wire logic opt_ext_stop,
  input wire logic nmi_pin,
  input wire logic irq_req,
  output logic wdg_reset,
  output logic nmi_irq,
  output logic core_wait,
  output logic core_stop
);
  // Synchronisers for pins and option straps
  logic [2:0] sync1_reg; // First stage, read only by the second
  logic [2:0] sync2_reg; // Second stage: nmi, hardware, external stop
  logic nmi_d_reg; // Delayed pin for edge detection
  logic hw_opt;
  logic ext_opt;
  logic nmi_s;
  logic nmi_fall;

  // Counter state
  logic [6:0] cnt_reg; // Physical counter, bit 6 is the reset bit
  logic [6:0] cnt_next;
  logic c_reg; // Software activation latch
  logic c_next;
  logic rst_reg; // Registered reset pulse
  logic rst_next;
  logic nmi_irq_reg;
  logic active;
  logic tick;
  logic pre_clear;

  // Control and power state
  logic gen_reg; // Global interrupt enable
  logic gen_next;
  wdg_pwr_e pwr_reg;
  wdg_pwr_e pwr_next;
  logic wake;

  // Bus decode
  logic apb_setup;
  logic apb_wr;
  logic hit_cnt;
  logic hit_ctl;
  logic wr_cnt;
  logic wr_ctl;
  logic stop_cmd;
  logic wait_cmd;
  logic [7:0] cnt_view; // Counter as software sees it
  logic [7:0] ctl_view;
  logic [6:0] wr_phys; // Write data in physical order
  logic [31:0] prdata_reg;
  logic [31:0] prdata_next;

  assign hw_opt = sync2_reg[1];
  assign ext_opt = sync2_reg[0];
  assign nmi_s = sync2_reg[2];
  // Interrupt pin request is its falling edge
  assign nmi_fall = nmi_d_reg && !nmi_s;

  // Synchronise pins; straps are taken only after reset release
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_reg <= 3'h4;
      sync2_reg <= 3'h4;
      nmi_d_reg <= 1'b1;
    end else begin
      sync1_reg <= {nmi_pin, opt_hw_activation, opt_ext_stop};
      sync2_reg <= sync1_reg;
      nmi_d_reg <= sync2_reg[2];
    end
  end

  // APB decode: zero wait states, unmapped access gives an error
  assign hit_cnt = (paddr == WDG_CNT_ADDR);
  assign hit_ctl = (paddr == WDG_CTL_ADDR);
  assign apb_setup = psel && !penable;
  assign apb_wr = psel && penable && pwrite;
  assign wr_cnt = apb_wr && hit_cnt;
  assign wr_ctl = apb_wr && hit_ctl;
  assign stop_cmd = wr_ctl && pwdata[CTL_STOP_POS];
  assign wait_cmd = wr_ctl && pwdata[CTL_WAIT_POS];
  assign pready = 1'b1;
  assign pslverr = psel && penable && !hit_cnt && !hit_ctl;

  // Reversed mapping between register view and physical counter
  genvar g;
  generate
    for (g = 0; g < WDG_T_BITS; g++) begin : g_map
      assign cnt_view[WDG_T_LSB + g] = cnt_reg[5 - g];
      assign wr_phys[5 - g] = pwdata[WDG_T_LSB + g];
    end
  endgenerate
  assign cnt_view[WDG_SR_POS] = cnt_reg[6];
  assign cnt_view[WDG_C_POS] = active;
  assign wr_phys[6] = pwdata[WDG_SR_POS];
  assign active = c_reg || hw_opt;

  assign ctl_view = {hw_opt, active, pwr_reg == WDG_STOP,
                     pwr_reg == WDG_WAIT, 3'h0, gen_reg};

  // Restart the step on reload or activation, freeze in STOP
  assign pre_clear = wr_cnt || (c_next && !c_reg);

  wdg_prescaler u_pre (
    .pclk(pclk),
    .presetn(presetn),
    .run(pwr_reg != WDG_STOP),
    .clear(pre_clear),
    .tick(tick)
  );

  // Counter next state: reload on write, else one step per tick
  always_comb begin
    cnt_next = cnt_reg;
    c_next = c_reg;
    if (wr_cnt) begin
      cnt_next = wr_phys;
      c_next = c_reg || pwdata[WDG_C_POS];
    end else if (tick) begin
      cnt_next = cnt_reg - 7'h01;
    end
    // Reset only on a falling reset bit with the watchdog active
    rst_next = cnt_reg[6] && !cnt_next[6] && (c_next || hw_opt);
  end

  // Register the counter group
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_reg <= WDG_PHYS_RESET;
      c_reg <= 1'b0;
      rst_reg <= 1'b0;
      nmi_irq_reg <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      c_reg <= c_next;
      rst_reg <= rst_next;
      nmi_irq_reg <= nmi_fall;
    end
  end

  // Wake needs an interrupt and the global enable
  assign wake = gen_reg && (irq_req || nmi_fall);

  // Power state next values
  always_comb begin
    pwr_next = pwr_reg;
    gen_next = wr_ctl ? pwdata[CTL_GEN_POS] : gen_reg;
    case (pwr_reg)
      WDG_RUN: begin
        if (stop_cmd) begin
          if (!active || (ext_opt && nmi_s)) begin
            pwr_next = WDG_STOP;
          end else begin
            pwr_next = WDG_WAIT;
          end
        end else if (wait_cmd) begin
          pwr_next = WDG_WAIT;
        end
      end
      WDG_WAIT, WDG_STOP: begin
        if (wake) begin
          pwr_next = WDG_RUN;
        end
      end
      default: begin
        pwr_next = WDG_RUN;
      end
    endcase
  end

  // Register the power group
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pwr_reg <= WDG_RUN;
      gen_reg <= 1'b0;
    end else begin
      pwr_reg <= pwr_next;
      gen_reg <= gen_next;
    end
  end

  // Read data captured in the setup phase
  always_comb begin
    prdata_next = prdata_reg;
    if (apb_setup && !pwrite) begin
      prdata_next = 32'h0000_0000;
      if (hit_cnt) begin
        prdata_next[7:0] = cnt_view;
      end else if (hit_ctl) begin
        prdata_next[7:0] = ctl_view;
      end
    end
  end

  // Register read data
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg <= 32'h0000_0000;
    end else begin
      prdata_reg <= prdata_next;
    end
  end

  assign prdata = prdata_reg;
  assign wdg_reset = rst_reg;
  assign nmi_irq = nmi_irq_reg;
  assign core_wait = (pwr_reg == WDG_WAIT);
  assign core_stop = (pwr_reg == WDG_STOP);

  // Checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic init_done_reg; // Low only in the first cycle after reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      init_done_reg <= 1'b0;
    end else begin
      init_done_reg <= 1'b1;
    end
  end

  property p_rst_val;
    !init_done_reg |-> cnt_reg == WDG_PHYS_RESET && !c_reg;
  endproperty
  a_rst_val: assert property (p_rst_val)
    else $error("counter not at reset value");
  property p_sr_fall;
    $past(cnt_reg[6]) && !cnt_reg[6] && active |-> wdg_reset;
  endproperty
  a_sr_fall: assert property (p_sr_fall)
    else $error("reset bit fell without reset");
  property p_map;
    wr_cnt |=> cnt_reg[0] == $past(pwdata[7])
      && cnt_reg[5] == $past(pwdata[2]) && cnt_reg[6] == $past(pwdata[1]);
  endproperty
  a_map: assert property (p_map)
    else $error("period bits not reversed on write");
  property p_step;
    tick && !wr_cnt |=> cnt_reg == $past(cnt_reg) - 7'h01;
  endproperty
  a_step: assert property (p_step)
    else $error("counter did not step on tick");
  property p_hw;
    hw_opt |-> cnt_view[WDG_C_POS];
  endproperty
  a_hw: assert property (p_hw)
    else $error("hardware option not forcing activation");
  property p_sticky;
    c_reg |=> c_reg;
  endproperty
  a_sticky: assert property (p_sticky)
    else $error("activation bit cleared");
  property p_no_rst_idle;
    wdg_reset |-> active;
  endproperty
  a_no_rst_idle: assert property (p_no_rst_idle)
    else $error("reset while watchdog inactive");
  property p_guard;
    $rose(c_reg) |-> !tick ##1 !tick[*8];
  endproperty
  a_guard: assert property (p_guard)
    else $error("step too soon after activation");
  property p_gen_wake;
    pwr_reg != WDG_RUN && !gen_reg |=> pwr_reg != WDG_RUN;
  endproperty
  a_gen_wake: assert property (p_gen_wake)
    else $error("woke with interrupts disabled");
  property p_read;
    apb_setup && !pwrite && hit_cnt |=> prdata[7] == $past(cnt_reg[0])
      && prdata[1] == $past(cnt_reg[6]);
  endproperty
  a_read: assert property (p_read)
    else $error("read view not reversed");
  property p_stop_wait;
    pwr_reg == WDG_RUN && stop_cmd && active && !ext_opt
      |=> pwr_reg == WDG_WAIT;
  endproperty
  a_stop_wait: assert property (p_stop_wait)
    else $error("STOP not treated as WAIT");
  property p_freeze;
    pwr_reg == WDG_STOP && !wr_cnt |=> cnt_reg == $past(cnt_reg);
  endproperty
  a_freeze: assert property (p_freeze)
    else $error("counter moved in STOP");
  c_reset: cover property (wdg_reset);
  c_stop: cover property (pwr_reg == WDG_RUN ##1 pwr_reg == WDG_STOP);
  c_wait: cover property (pwr_reg == WDG_RUN ##1 pwr_reg == WDG_WAIT);
  c_wake: cover property (pwr_reg == WDG_STOP ##1 pwr_reg == WDG_RUN);
endmodule : wdg_top

// ==== verification/tb_wdg_top.sv ====
// Self-checking bench for the watchdog downcounter block
`timescale 1ns/100ps
module tb_wdg_top import wdg_pkg::*;;
  // Strap, pin and nmi level per case {hw, ext, nmi, stop expected}
  localparam logic [15:0] STOP_CASES = 16'hcfa3;
  logic pclk = 0; // Bus clock
  logic presetn = 0; // Reset, active low
  logic psel = 0;
  logic penable = 0;
  logic pwrite = 0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, wdg_reset, nmi_irq, core_wait, core_stop;
  logic opt_hw_activation = 0;
  logic opt_ext_stop = 0;
  logic nmi_pin = 1; // Pin idles high so STOP stays reachable
  logic irq_req = 0;
  int err_count = 0;
  int checks_done = 0;
  int rst_cnt = 0; // Reset pulses seen
  int nmi_cnt = 0; // Interrupt pulses seen
  int c;
  integer seed = 32'hdb78;
  integer v;
  logic [6:0] p;
  logic [3:0] cs;
  logic [32:0] exp_q[$]; // Expected {pslverr, prdata} per read
  logic [32:0] e;

  // Free-running clock, 40 ns period
  always #20 pclk = ~pclk;

  wdg_top i_wdg_top (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .opt_hw_activation,
    .opt_ext_stop, .nmi_pin, .irq_req, .wdg_reset, .nmi_irq, .core_wait,
    .core_stop);

  // Compare and count
  task chk(input string nm, input logic [32:0] x, input logic [32:0] g);
    checks_done++;
    if (x !== g) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", nm, x, g);
    end
  endtask : chk

  // Verdict and end of run
  task conclude;
    if (err_count == 0 && checks_done > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : conclude

  // Output watcher: pulse counts and read results against the queue
  always @(posedge pclk) begin
    if (wdg_reset === 1'b1) rst_cnt++;
    if (nmi_irq === 1'b1) nmi_cnt++;
    if (psel && penable && pready === 1'b1 && !pwrite && exp_q.size() > 0) begin
      e = exp_q.pop_front();
      chk("read", e, {pslverr, prdata});
    end
  end

  // Register view of a physical counter value, period bits reversed
  function automatic logic [7:0] rv(input logic a, input logic [6:0] q);
    logic [7:0] r;
    r[0] = a;
    r[1] = q[6];
    for (int i = 0; i < 6; i++) r[7 - i] = q[i];
    return r;
  endfunction : rv

  // One APB transfer, held until pready is sampled high
  task apb(input logic w, input logic [7:0] a, input logic [7:0] d,
      input logic [32:0] x);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    if (!w) exp_q.push_back(x);
    @(posedge pclk);
    penable <= 1;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 20) begin
      @(posedge pclk);
      n++;
    end
    if (n == 20) begin
      err_count++;
      conclude();
    end
    psel <= 0;
    penable <= 0;
  endtask : apb

  task wr(input logic [7:0] a, input logic [7:0] d);
    apb(1, a, d, 33'h0);
  endtask : wr

  task rd(input logic [7:0] a, input logic [7:0] b);
    apb(0, a, 8'h00, {25'h0, b});
  endtask : rd

  // Count cycles from the last access edge to a reset pulse
  task wait_rst(input int lo, input int hi);
    int n;
    int c0;
    n = 0;
    c0 = rst_cnt;
    while (rst_cnt == c0 && n <= hi) begin
      @(posedge pclk);
      #1;
      n++;
    end
    if (rst_cnt == c0) begin
      err_count++;
      conclude();
    end
    chk("reset delay", 33'h1, 33'(n >= lo && n <= hi));
  endtask : wait_rst

  // Reset with the given straps, then let the synchronisers settle
  task do_reset(input logic hw, input logic ext);
    @(posedge pclk);
    presetn <= 0;
    opt_hw_activation <= hw;
    opt_ext_stop <= ext;
    repeat (6) @(posedge pclk);
    presetn <= 1;
    repeat (4) @(posedge pclk);
  endtask : do_reset

  // Main sequence
  initial begin
    do_reset(0, 0);
    rd(WDG_CNT_ADDR, WDG_CNT_RESET);
    rd(WDG_CTL_ADDR, 8'h00);
    apb(0, 8'h40, 8'h00, {1'b1, 32'h0});
    repeat (4) begin
      v = $random(seed);
      p = {1'b1, v[5:0]};
      wr(WDG_CNT_ADDR, rv(0, p));
      rd(WDG_CNT_ADDR, rv(0, p));
    end
    c = rst_cnt;
    wr(WDG_CNT_ADDR, rv(0, 7'h25));
    repeat (3100) @(posedge pclk);
    rd(WDG_CNT_ADDR, rv(0, 7'h24));
    wr(WDG_CNT_ADDR, 8'h00);
    repeat (3100) @(posedge pclk);
    rd(WDG_CNT_ADDR, rv(0, 7'h7f));
    #1;
    chk("no reset", 33'(c), 33'(rst_cnt));
    wr(WDG_CNT_ADDR, rv(1, 7'h41));
    wr(WDG_CNT_ADDR, rv(0, 7'h41));
    wait_rst(6144, 6147);
    rd(WDG_CNT_ADDR, rv(1, 7'h3f));
    // Reload first: the reset bit is already low after the timeout
    wr(WDG_CNT_ADDR, rv(1, 7'h7f));
    // Clearing the reset bit by software now gives an immediate reset
    wr(WDG_CNT_ADDR, rv(1, 7'h01));
    wait_rst(1, 3);
    do_reset(1, 0);
    rd(WDG_CNT_ADDR, 8'hff);
    wr(WDG_CNT_ADDR, 8'hfe);
    rd(WDG_CNT_ADDR, 8'hff);
    rd(WDG_CTL_ADDR, 8'hc0);
    // WAIT command with the global enable set, then wake on a request
    wr(WDG_CTL_ADDR, 8'h05);
    rd(WDG_CTL_ADDR, 8'hd1);
    irq_req <= 1;
    repeat (2) @(posedge pclk);
    #1;
    chk("irq wake", 33'h0, {31'h0, core_wait, core_stop});
    @(posedge pclk);
    irq_req <= 0;
    for (int i = 0; i < 4; i++) begin
      cs = STOP_CASES[4*i +: 4];
      do_reset(cs[3], cs[2]);
      nmi_pin <= cs[1];
      repeat (4) @(posedge pclk);
      wr(WDG_CTL_ADDR, 8'h02);
      repeat (3200) @(posedge pclk);
      rd(WDG_CNT_ADDR, rv(cs[3], cs[0] ? 7'h7f : 7'h7e));
      chk("sleep", {31'h0, ~cs[0], cs[0]}, {31'h0, core_wait, core_stop});
      c = nmi_cnt;
      nmi_pin <= 1;
      repeat (4) @(posedge pclk);
      nmi_pin <= 0;
      irq_req <= 1;
      repeat (6) @(posedge pclk);
      #1;
      chk("nmi", 33'(c + 1), 33'(nmi_cnt));
      chk("held", {31'h0, ~cs[0], cs[0]}, {31'h0, core_wait, core_stop});
      wr(WDG_CTL_ADDR, 8'h01);
      repeat (3) @(posedge pclk);
      #1;
      chk("woken", 33'h0, {31'h0, core_wait, core_stop});
      @(posedge pclk);
      irq_req <= 0;
      nmi_pin <= 1;
    end
    conclude();
  end
endmodule : tb_wdg_top
